// *** common/pixel_post_defines.svh ***
`ifndef PIXEL_POST_DEFINES_SVH
`define PIXEL_POST_DEFINES_SVH

// Register indices; the Avalon byte address of each is four times its index.
`define PPC_IDX_PSEUDO        12'h0844
`define PPC_IDX_FETCH_ONE     12'h0846
`define PPC_IDX_FETCH_TWO     12'h0848
`define PPC_IDX_OVL_ONE_XS    12'h084a

// Reset values.
`define PPC_RST_PSEUDO        16'h0000
`define PPC_RST_FETCH         16'h01ff
`define PPC_RST_OVL_ONE_XS    16'h0000

// Field positions and widths.
`define PPC_MODE_MSB          2
`define PPC_THR_MSB           8
`define PPC_THR_RSVD_BIT      15
`define PPC_XS_MSB            10

// Pseudo colour selector codes.
`define PPC_CODE_OFF          3'h0
`define PPC_CODE_MATRIX       3'h1
`define PPC_CODE_FRM          3'h2
`define PPC_CODE_DIFFUSE      3'h4

// Component widths: passive panels without pseudo colour show 4 bits per component.
`define PPC_PASSIVE_OFF_WIDTH 4'h4
`define PPC_MIN_WIDTH         4'h4
`define PPC_MAX_WIDTH         4'h8

// Passive panel types.
`define PPC_PANEL_MONO        3'h0
`define PPC_PANEL_COLOUR      3'h2

`endif

// *** common/pixel_post_pkg.sv ***
package pixel_post_pkg;

	typedef enum logic [2:0] {
		PC_OFF     = 3'h0,
		PC_MATRIX  = 3'h1,
		PC_FRM     = 3'h2,
		PC_DIFFUSE = 3'h4
	} pseudo_mode_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} bus_state_t;

	typedef logic [7:0] comp_t;

endpackage

// *** src/display_pixel_post_config.sv ***
// Summary of operation
// - Decode 3-bit selector: off, matrix dither, frame rate modulation, error diffusion.
// - Selector off truncates each component to the panel bus width (four bits on passive panels), never rounds.
// - Passive panels run one identical pseudo colour operation for codes 1, 2, 4.
// - Passive colour panel without pseudo colour is limited to 4096 colours.
// - Passive mono panel without pseudo colour is limited to 16 gray shades.
// - Request a fetch for buffer one while its pointer difference is below threshold.
// - Request a fetch for buffer two while its pointer difference is below threshold.
// - Overlay one horizontal start is stored in 2-pixel units from origin.
`timescale 1ns/1ns
`include "pixel_post_defines.svh"

module display_pixel_post_config import pixel_post_pkg::*; (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// Avalon-MM register slave
	input  wire logic [13:0] ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [31:0] WRITEDATA,
	input  wire logic [3:0]  BYTEENABLE,
	output logic      [31:0] READDATA,
	output logic             WAITREQUEST,
	// Panel configuration
	input  wire logic        PANEL_PASSIVE,
	input  wire logic [2:0]  PANEL_TYPE,
	input  wire logic [3:0]  PANEL_BUS_WIDTH,
	// Pixel stream in
	input  wire logic        PIXEL_VALID,
	input  wire logic        PIXEL_X_ODD,
	input  wire logic        PIXEL_Y_ODD,
	input  wire logic        FRAME_ODD,
	input  wire logic [7:0]  PIXEL_RED,
	input  wire logic [7:0]  PIXEL_GREEN,
	input  wire logic [7:0]  PIXEL_BLUE,
	// Pixel stream out
	output logic             OUT_VALID,
	output logic      [7:0]  OUT_RED,
	output logic      [7:0]  OUT_GREEN,
	output logic      [7:0]  OUT_BLUE,
	// Fetch buffers
	input  wire logic [8:0]  FETCH_ONE_RD_PTR,
	input  wire logic [8:0]  FETCH_ONE_WR_PTR,
	input  wire logic [8:0]  FETCH_TWO_RD_PTR,
	input  wire logic [8:0]  FETCH_TWO_WR_PTR,
	output logic             FETCH_ONE_REQ,
	output logic             FETCH_TWO_REQ,
	// Overlay window one
	output logic      [11:0] OVERLAY_ONE_X_START
);

	function automatic logic pc_enabled(input logic [2:0] code);
		return code == `PPC_CODE_MATRIX || code == `PPC_CODE_FRM ||
			code == `PPC_CODE_DIFFUSE;
	endfunction

	function automatic logic [7:0] low_mask(input logic [3:0] w);
		return 8'hff >> w;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic hit(input logic [13:0] addr, input logic [11:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	// Register bus.
	bus_state_t  bus_state;
	bus_state_t  next_bus_state;
	logic [15:0] pseudo_reg;
	logic [15:0] fetch_one_reg;
	logic [15:0] fetch_two_reg;
	logic [15:0] ovl_xs_reg;
	logic [15:0] next_pseudo_reg;
	logic [15:0] next_fetch_one_reg;
	logic [15:0] next_fetch_two_reg;
	logic [15:0] next_ovl_xs_reg;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic        accept_wr;

	always_comb begin
		accept_wr          = bus_state == BUS_ACK && WRITE;
		next_bus_state     = BUS_IDLE;
		next_waitrequest   = 1'b1;
		next_readdata      = READDATA;
		next_pseudo_reg    = pseudo_reg;
		next_fetch_one_reg = fetch_one_reg;
		next_fetch_two_reg = fetch_two_reg;
		next_ovl_xs_reg    = ovl_xs_reg;
		if (bus_state == BUS_IDLE && (READ || WRITE)) begin
			next_bus_state   = BUS_ACK;
			next_waitrequest = 1'b0;
			next_readdata    = 32'h0000_0000;
			if (hit(ADDRESS, `PPC_IDX_PSEUDO))
				next_readdata[`PPC_MODE_MSB:0] = pseudo_reg[`PPC_MODE_MSB:0];
			else if (hit(ADDRESS, `PPC_IDX_FETCH_ONE))
				next_readdata[15:0] = fetch_one_reg;
			else if (hit(ADDRESS, `PPC_IDX_FETCH_TWO))
				next_readdata[15:0] = fetch_two_reg;
			else if (hit(ADDRESS, `PPC_IDX_OVL_ONE_XS))
				next_readdata[`PPC_XS_MSB:0] = ovl_xs_reg[`PPC_XS_MSB:0];
		end
		if (accept_wr) begin
			if (hit(ADDRESS, `PPC_IDX_PSEUDO))
				next_pseudo_reg = merge16(pseudo_reg, WRITEDATA, BYTEENABLE) &
					16'h0007;
			if (hit(ADDRESS, `PPC_IDX_FETCH_ONE))
				next_fetch_one_reg = merge16(fetch_one_reg, WRITEDATA, BYTEENABLE) &
					16'h81ff;
			if (hit(ADDRESS, `PPC_IDX_FETCH_TWO))
				next_fetch_two_reg = merge16(fetch_two_reg, WRITEDATA, BYTEENABLE) &
					16'h81ff;
			if (hit(ADDRESS, `PPC_IDX_OVL_ONE_XS))
				next_ovl_xs_reg = merge16(ovl_xs_reg, WRITEDATA, BYTEENABLE) &
					16'h07ff;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			bus_state     <= BUS_IDLE;
			WAITREQUEST   <= 1'b1;
			READDATA      <= 32'h0000_0000;
			pseudo_reg    <= `PPC_RST_PSEUDO;
			fetch_one_reg <= `PPC_RST_FETCH;
			fetch_two_reg <= `PPC_RST_FETCH;
			ovl_xs_reg    <= `PPC_RST_OVL_ONE_XS;
		end else begin
			bus_state     <= next_bus_state;
			WAITREQUEST   <= next_waitrequest;
			READDATA      <= next_readdata;
			pseudo_reg    <= next_pseudo_reg;
			fetch_one_reg <= next_fetch_one_reg;
			fetch_two_reg <= next_fetch_two_reg;
			ovl_xs_reg    <= next_ovl_xs_reg;
		end
	end

	// Overlay start in pixels; the field counts pairs of pixels.
	logic [11:0] next_ovl_x;

	always_comb begin
		next_ovl_x = {ovl_xs_reg[`PPC_XS_MSB:0], 1'b0};
	end

	// Fetch requests, one compare per buffer each clock.
	logic [8:0] diff_one;
	logic [8:0] diff_two;
	logic       next_req_one;
	logic       next_req_two;

	always_comb begin
		diff_one     = FETCH_ONE_WR_PTR - FETCH_ONE_RD_PTR;
		diff_two     = FETCH_TWO_WR_PTR - FETCH_TWO_RD_PTR;
		next_req_one = diff_one < fetch_one_reg[`PPC_THR_MSB:0];
		next_req_two = diff_two < fetch_two_reg[`PPC_THR_MSB:0];
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			FETCH_ONE_REQ       <= 1'b0;
			FETCH_TWO_REQ       <= 1'b0;
			OVERLAY_ONE_X_START <= 12'h000;
		end else begin
			FETCH_ONE_REQ       <= next_req_one;
			FETCH_TWO_REQ       <= next_req_two;
			OVERLAY_ONE_X_START <= next_ovl_x;
		end
	end

	// Pseudo colour processing. Reserved codes fall back to plain truncation.
	logic [2:0] mode;
	logic       pc_on;
	logic [3:0] eff_w;
	logic [1:0] thresh;
	logic       use_diffusion;
	comp_t      pix_in [3];
	comp_t      pix_out [3];
	comp_t      err [3];

	always_comb begin
		mode          = pseudo_reg[`PPC_MODE_MSB:0];
		pc_on         = pc_enabled(mode);
		pix_in[0]     = PIXEL_RED;
		pix_in[1]     = PIXEL_GREEN;
		pix_in[2]     = PIXEL_BLUE;
		// Passive panels take the same matrix pattern whichever code enables it.
		use_diffusion = !PANEL_PASSIVE && mode == `PPC_CODE_DIFFUSE;
		if (PANEL_PASSIVE || mode == `PPC_CODE_MATRIX)
			thresh = {PIXEL_X_ODD ^ PIXEL_Y_ODD, PIXEL_Y_ODD};
		else
			thresh = {FRAME_ODD, FRAME_ODD ^ PIXEL_X_ODD};
		// Without pseudo colour a passive panel keeps four bits per component.
		if (PANEL_PASSIVE && !pc_on)
			eff_w = `PPC_PASSIVE_OFF_WIDTH;
		else if (PANEL_BUS_WIDTH < `PPC_MIN_WIDTH)
			eff_w = `PPC_MIN_WIDTH;
		else if (PANEL_BUS_WIDTH > `PPC_MAX_WIDTH)
			eff_w = `PPC_MAX_WIDTH;
		else
			eff_w = PANEL_BUS_WIDTH;
	end

	generate
		for (genvar c = 0; c < 3; c++) begin : g_comp
			logic [8:0] sum;
			comp_t      sat;
			comp_t      offset;
			comp_t      next_out;
			comp_t      next_err;

			always_comb begin
				offset   = use_diffusion ? err[c] : ({thresh, 6'h00} >> eff_w);
				sum      = {1'b0, pix_in[c]} + {1'b0, offset};
				// Saturate so white never wraps to black.
				sat      = sum[8] ? 8'hff : sum[7:0];
				next_err = err[c];
				if (pc_on) begin
					next_out = sat & ~low_mask(eff_w);
					if (PIXEL_VALID && use_diffusion)
						next_err = sat & low_mask(eff_w);
				end else begin
					next_out = pix_in[c] & ~low_mask(eff_w);
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (RST) begin
					pix_out[c] <= 8'h00;
					err[c]     <= 8'h00;
				end else begin
					pix_out[c] <= PIXEL_VALID ? next_out : pix_out[c];
					err[c]     <= next_err;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS) begin
		if (RST)
			OUT_VALID <= 1'b0;
		else
			OUT_VALID <= PIXEL_VALID;
	end

	assign OUT_RED   = pix_out[0];
	assign OUT_GREEN = pix_out[1];
	assign OUT_BLUE  = pix_out[2];

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	property p_mode_store;
		accept_wr && hit(ADDRESS, `PPC_IDX_PSEUDO) && BYTEENABLE[0] |=>
			mode == $past(WRITEDATA[2:0]);
	endproperty
	a_mode_store: assert property (p_mode_store) else $error("selector not stored");

	property p_trunc_off;
		PIXEL_VALID && mode == `PPC_CODE_OFF && !PANEL_PASSIVE && PANEL_BUS_WIDTH == 4'h5 |=>
			OUT_RED == ($past(PIXEL_RED) & 8'hf8);
	endproperty
	a_trunc_off: assert property (p_trunc_off) else $error("off mode not truncating");

	property p_reserved_off;
		PIXEL_VALID && (mode == 3'h3 || mode > `PPC_CODE_DIFFUSE) && !PANEL_PASSIVE &&
			PANEL_BUS_WIDTH == 4'h5 |=>
			OUT_GREEN == ($past(PIXEL_GREEN) & 8'hf8);
	endproperty
	a_reserved_off: assert property (p_reserved_off) else $error("reserved code not off");

	property p_passive_colour;
		PIXEL_VALID && PANEL_PASSIVE && PANEL_TYPE == `PPC_PANEL_COLOUR && !pc_on |=>
			OUT_BLUE[3:0] == 4'h0;
	endproperty
	a_passive_colour: assert property (p_passive_colour) else $error("too many colours");

	property p_passive_mono;
		PIXEL_VALID && PANEL_PASSIVE && PANEL_TYPE == `PPC_PANEL_MONO && !pc_on |=>
			OUT_RED[3:0] == 4'h0;
	endproperty
	a_passive_mono: assert property (p_passive_mono) else $error("too many gray shades");

	property p_passive_same;
		PIXEL_VALID && PANEL_PASSIVE && pc_on && !PIXEL_X_ODD && !PIXEL_Y_ODD |=>
			OUT_RED == ($past(PIXEL_RED) & ~low_mask($past(eff_w)));
	endproperty
	a_passive_same: assert property (p_passive_same) else $error("passive modes differ");

	property p_req_one;
		(FETCH_ONE_WR_PTR - FETCH_ONE_RD_PTR) < fetch_one_reg[8:0] |=> FETCH_ONE_REQ;
	endproperty
	a_req_one: assert property (p_req_one) else $error("buffer one request missing");

	property p_req_two;
		(FETCH_TWO_WR_PTR - FETCH_TWO_RD_PTR) >= fetch_two_reg[8:0] |=> !FETCH_TWO_REQ;
	endproperty
	a_req_two: assert property (p_req_two) else $error("buffer two request spurious");

	property p_ovl_start;
		accept_wr && hit(ADDRESS, `PPC_IDX_OVL_ONE_XS) && BYTEENABLE[1:0] == 2'b11 |=> ##1
			OVERLAY_ONE_X_START == {$past(WRITEDATA[10:0], 2), 1'b0};
	endproperty
	a_ovl_start: assert property (p_ovl_start) else $error("overlay start wrong");

	property p_bus_ack;
		(READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle");

	c_diffuse: cover property (PIXEL_VALID && use_diffusion);
	c_req_one: cover property (!FETCH_ONE_REQ ##1 FETCH_ONE_REQ);
	c_passive_on: cover property (PIXEL_VALID && PANEL_PASSIVE && pc_on);

endmodule

// *** verification/fetch_buffer_model.sv ***
`timescale 1ns/1ns

// Fetch buffer with its memory: a word arrives on every cycle with a request.
module fetch_buffer_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Fetch control
	input  wire logic       req,
	input  wire logic       drain,
	// Pointers
	output logic      [8:0] rd_ptr,
	output logic      [8:0] wr_ptr
);
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ptr <= 9'h000;
			wr_ptr <= 9'h000;
		end else begin
			// Memory answers at once; a slow panel is drain held low.
			if (req)
				wr_ptr <= wr_ptr + 9'h001;
			if (drain && rd_ptr != wr_ptr)
				rd_ptr <= rd_ptr + 9'h001;
		end
	end
endmodule

// *** verification/display_pixel_post_config_tb.sv ***
`timescale 1ns/1ns
`include "pixel_post_defines.svh"

module display_pixel_post_config_tb;
	logic        clk_sys = 0, rst = 1, read = 0, write = 0;
	logic [13:0] address = 0;
	logic [31:0] writedata = 0, readdata, q;
	logic        waitrequest, passive = 0, valid = 0, x_odd = 0, drn = 0;
	logic        y_odd = 0, frame_rate_modulation = 0;
	logic [2:0]  ptype = 0;
	logic [3:0]  bwidth = 4'h5;
	logic [7:0]  pin = 0, ored, ogrn, oblu, first;
	logic        ovalid, req1, req2;
	logic [8:0]  r1, w1, r2, w2;
	logic [11:0] xstart;
	logic        e1, e2;
	int          err_total = 0, check_count = 0, i;
	logic [43:0] rows [6] = '{
		{`PPC_IDX_PSEUDO, 16'h0004, 16'h0004},
		{`PPC_IDX_PSEUDO, 16'hfffb, 16'h0003},
		{`PPC_IDX_FETCH_ONE, 16'h8123, 16'h8123},
		{`PPC_IDX_FETCH_TWO, 16'h7e05, 16'h0005},
		{12'h0850, 16'h1234, 16'h0000},
		{`PPC_IDX_OVL_ONE_XS, 16'hf808, 16'h0008}};
	// Overlay start is written while no pixels flow, at a multiple of eight pixels.

	always #5 clk_sys = ~clk_sys;

	display_pixel_post_config dut_u (.CLK_SYS(clk_sys), .RST(rst), .ADDRESS(address),
		.READ(read), .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(4'h3),
		.READDATA(readdata), .WAITREQUEST(waitrequest), .PANEL_PASSIVE(passive),
		.PANEL_TYPE(ptype), .PANEL_BUS_WIDTH(bwidth), .PIXEL_VALID(valid),
		.PIXEL_X_ODD(x_odd), .PIXEL_Y_ODD(y_odd), .FRAME_ODD(frame_rate_modulation), .PIXEL_RED(pin),
		.PIXEL_GREEN(pin), .PIXEL_BLUE(pin), .OUT_VALID(ovalid), .OUT_RED(ored),
		.OUT_GREEN(ogrn), .OUT_BLUE(oblu), .FETCH_ONE_RD_PTR(r1), .FETCH_ONE_WR_PTR(w1),
		.FETCH_TWO_RD_PTR(r2), .FETCH_TWO_WR_PTR(w2), .FETCH_ONE_REQ(req1),
		.FETCH_TWO_REQ(req2), .OVERLAY_ONE_X_START(xstart));
	fetch_buffer_model buf_one (.clk(clk_sys), .rst(rst), .req(req1), .drain(drn),
		.rd_ptr(r1), .wr_ptr(w1));
	fetch_buffer_model buf_two (.clk(clk_sys), .rst(rst), .req(req2), .drain(drn),
		.rd_ptr(r2), .wr_ptr(w2));

	task results;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request stays up, fields unchanged, until waitrequest is seen low.
	task bus(input logic w, input logic [11:0] idx, input logic [15:0] d);
		int n;
		@(posedge clk_sys);
		read <= !w;
		write <= w;
		address <= {idx, 2'b00};
		writedata <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n == 50) begin
			err_total++;
			results;
		end
	endtask

	task pix(input logic [7:0] v, input logic [7:0] exp);
		@(posedge clk_sys);
		valid <= 1'b1;
		pin <= v;
		@(posedge clk_sys);
		valid <= 1'b0;
		#1;
		chk(32'(ovalid), 32'h0000_0001);
		chk(32'({ored, ogrn, oblu}), 32'({exp, exp, exp}));
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b1, `PPC_IDX_FETCH_ONE, 16'h0008);
		bus(1'b1, `PPC_IDX_FETCH_TWO, 16'h000c);
		#1;
		for (i = 0; i < 150; i++) begin
			e1 = 9'(w1 - r1) < 9'h008;
			e2 = 9'(w2 - r2) < 9'h00c;
			@(posedge clk_sys);
			drn <= i[2] | i[1];
			#1;
			chk(32'(req1), 32'(e1));
			chk(32'(req2), 32'(e2));
		end
		for (i = 0; i < 6; i++) begin
			bus(1'b1, rows[i][43:32], rows[i][31:16]);
			bus(1'b0, rows[i][43:32], 16'h0000);
			chk(q, {16'h0000, rows[i][15:0]});
		end
		#1;
		chk(32'(xstart), 32'h0000_0010);
		bus(1'b1, `PPC_IDX_PSEUDO, 16'h0000);
		pix(8'h87, 8'h80);
		pix(8'hff, 8'hf8);
		bus(1'b1, `PPC_IDX_PSEUDO, 16'h0006);
		pix(8'h87, 8'h80);
		// Active panel, six bits kept: each enabled mode adds its own offset.
		bus(1'b1, `PPC_IDX_PSEUDO, 16'h0001);
		bwidth <= 4'h6;
		x_odd <= 1'b1;
		y_odd <= 1'b1;
		pix(8'h5b, 8'h5c);
		pix(8'hff, 8'hfc);
		bus(1'b1, `PPC_IDX_PSEUDO, 16'h0002);
		x_odd <= 1'b0;
		y_odd <= 1'b0;
		frame_rate_modulation <= 1'b1;
		pix(8'h59, 8'h5c);
		bus(1'b1, `PPC_IDX_PSEUDO, 16'h0004);
		frame_rate_modulation <= 1'b0;
		pix(8'h5a, 8'h58);
		pix(8'h5a, 8'h5c);
		bus(1'b1, `PPC_IDX_PSEUDO, 16'h0000);
		passive <= 1'b1;
		bwidth <= 4'h8;
		pix(8'h9f, 8'h90);
		@(posedge clk_sys);
		ptype <= `PPC_PANEL_COLOUR;
		pix(8'hab, 8'ha0);
		for (i = 0; i < 3; i++) begin
			bus(1'b1, `PPC_IDX_PSEUDO, 16'(1 << i));
			bwidth <= 4'h6;
			@(posedge clk_sys);
			valid <= 1'b1;
			pin <= 8'h5a;
			x_odd <= 1'b0;
			@(posedge clk_sys);
			x_odd <= 1'b1;
			@(posedge clk_sys);
			valid <= 1'b0;
			x_odd <= 1'b0;
			#1;
			if (i == 0)
				first = ored;
			chk(32'(ored), 32'(first));
			chk(32'(ored), 32'h0000_005c);
		end
		// Software keeps the buffer one threshold at its normal setting.
		bus(1'b1, `PPC_IDX_FETCH_ONE, 16'h01ff);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(32'({waitrequest, req1, req2, ovalid, ored, ogrn, oblu}), 32'h0800_0000);
		chk(32'(xstart), 32'h0000_0000);
		rst <= 1'b0;
		bus(1'b0, `PPC_IDX_PSEUDO, 16'h0000);
		chk(q, 32'h0000_0000);
		bus(1'b0, `PPC_IDX_FETCH_TWO, 16'h0000);
		chk(q, 32'h0000_01ff);
		bus(1'b0, `PPC_IDX_OVL_ONE_XS, 16'h0000);
		chk(q, 32'h0000_0000);
		results;
	end
endmodule
